//--- spi_master.sv
// Serial master with delayed clock phase behind a classic Wishbone slave.
// Assumes one 100 MHz clock; the serial input pin is asynchronous.
`timescale 1ns/1ps

module spi_master
(
	input  logic             core_clk,
	input  logic             sys_rst,
	input  spi_pkg::wb_req_t wb_req,
	output spi_pkg::wb_rsp_t wb_rsp,
	input  logic             master_in_line,
	output logic             serial_clock_line,
	output logic             master_out_line,
	output logic             slave_enable_line_n
);
	spi_pkg::core_state_t        q;
	spi_pkg::core_state_t        d;
	logic [spi_pkg::PER_W-1:0]   period;
	logic [spi_pkg::HALF_W-1:0]  act_len;
	logic [spi_pkg::HALF_W-1:0]  idle_len;
	logic [spi_pkg::HALF_W-1:0]  half_len;
	logic                        restart;
	logic                        done;
	logic                        enabled;
	logic                        wr;
	logic                        rd;
	logic                        last_bit;
	logic [spi_pkg::BITS_W-1:0]  word_bits;

	// Small settings fall back to the fixed period
	assign period = (q.div <= spi_pkg::DIV_SMALL_MAX) ? spi_pkg::MIN_PERIOD
		: {1'b0, q.div} + spi_pkg::PER_ONE;
	// Odd periods give the spare core clock to the idle half
	assign act_len  = period[spi_pkg::PER_W-1:1];
	assign idle_len = spi_pkg::HALF_W'(period - {1'b0, act_len});
	assign half_len = (q.st == spi_pkg::ST_ACT) ? act_len : idle_len;

	assign enabled   = q.master & q.phase;
	assign word_bits = {1'b0, q.len} + spi_pkg::BITS_ONE;
	assign last_bit  = (q.bits == word_bits);

	half_timer u_half_timer
	(
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.restart  (restart),
		.half_len (half_len),
		.done     (done)
	);

	always_comb
	begin
		d       = q;
		restart = 1'b0;
		d.sync0 = master_in_line;
		d.sync1 = q.sync0;
		// One wait state: ack follows the request by one edge, then drops
		d.ack = wb_req.cyc & wb_req.stb & ~q.ack;
		wr    = d.ack & wb_req.we;
		rd    = d.ack & ~wb_req.we;

		if (wr && wb_req.sel[0])
		begin
			case (wb_req.adr)
				spi_pkg::OFS_CFG:
				begin
					d.len = wb_req.dat[spi_pkg::CFG_LEN_LSB +: spi_pkg::LEN_W];
					d.pol = wb_req.dat[spi_pkg::CFG_POL_BIT];
				end
				spi_pkg::OFS_CTL:
				begin
					d.master = wb_req.dat[spi_pkg::CTL_MASTER_BIT];
					d.phase  = wb_req.dat[spi_pkg::CTL_PHASE_BIT];
				end
				spi_pkg::OFS_DIV:
					d.div = wb_req.dat[spi_pkg::DIV_W-1:0];
				default:
					d.div = d.div;
			endcase
		end

		d.rdat = spi_pkg::RD_ZERO;
		if (rd)
		begin
			case (wb_req.adr)
				spi_pkg::OFS_CFG:
				begin
					d.rdat[spi_pkg::CFG_LEN_LSB +: spi_pkg::LEN_W] = q.len;
					d.rdat[spi_pkg::CFG_POL_BIT] = q.pol;
				end
				spi_pkg::OFS_CTL:
				begin
					d.rdat[spi_pkg::CTL_MASTER_BIT] = q.master;
					d.rdat[spi_pkg::CTL_PHASE_BIT]  = q.phase;
				end
				spi_pkg::OFS_DIV:
					d.rdat[spi_pkg::DIV_W-1:0] = q.div;
				spi_pkg::OFS_STAT:
				begin
					d.rdat[spi_pkg::STAT_BUSY_BIT] = (q.st != spi_pkg::ST_IDLE);
					d.rdat[spi_pkg::STAT_TXF_BIT]  = q.tx_full;
					d.rdat[spi_pkg::STAT_RXF_BIT]  = q.rx_full;
					d.rdat[spi_pkg::STAT_TXOK_BIT] = (period >= spi_pkg::TX_MIN_CYC);
					d.rdat[spi_pkg::STAT_RXOK_BIT] = (period >= spi_pkg::RX_MIN_CYC);
				end
				spi_pkg::OFS_TX:
					d.rdat[spi_pkg::WORD_W-1:0] = q.txbuf;
				spi_pkg::OFS_RX:
				begin
					d.rdat[spi_pkg::WORD_W-1:0] = q.rxbuf;
					d.rx_full = 1'b0;
				end
				default:
					d.rdat = spi_pkg::RD_ZERO;
			endcase
		end

		case (q.st)
			spi_pkg::ST_IDLE:
			begin
				restart = 1'b1;
				d.sclk  = q.pol;
				d.ste_n = 1'b1;
				if (q.tx_full && enabled)
				begin
					// Enable and first bit go out together, a full idle half early
					d.st      = spi_pkg::ST_LEAD;
					d.ste_n   = 1'b0;
					d.sh      = q.txbuf;
					d.mosi    = q.txbuf[spi_pkg::WORD_W-1];
					d.tx_full = 1'b0;
					d.bits    = '0;
					d.rx      = spi_pkg::RST_WORD;
				end
			end
			spi_pkg::ST_LEAD, spi_pkg::ST_GAP:
			begin
				if (done)
				begin
					restart = 1'b1;
					d.st    = spi_pkg::ST_ACT;
					d.sclk  = ~q.pol;
					d.rx    = {q.rx[spi_pkg::WORD_W-2:0], q.sync1};
					d.bits  = q.bits + spi_pkg::BITS_ONE;
				end
			end
			spi_pkg::ST_ACT:
			begin
				if (done)
				begin
					restart = 1'b1;
					d.sclk  = q.pol;
					if (last_bit)
					begin
						d.rxbuf   = q.rx;
						d.rx_full = 1'b1;
						if (q.tx_full && enabled)
						begin
							// Next word follows with the enable held
							d.st      = spi_pkg::ST_LEAD;
							d.sh      = q.txbuf;
							d.mosi    = q.txbuf[spi_pkg::WORD_W-1];
							d.tx_full = 1'b0;
							d.bits    = '0;
							d.rx      = spi_pkg::RST_WORD;
						end
						else
						begin
							d.st    = spi_pkg::ST_IDLE;
							d.ste_n = 1'b1;
						end
					end
					else
					begin
						d.st   = spi_pkg::ST_GAP;
						d.sh   = {q.sh[spi_pkg::WORD_W-2:0], 1'b0};
						d.mosi = q.sh[spi_pkg::WORD_W-2];
					end
				end
			end
			default:
			begin
				restart = 1'b1;
				d.st    = spi_pkg::ST_IDLE;
			end
		endcase

		// A write in the cycle the engine takes the buffer keeps it full
		if (wr && wb_req.adr == spi_pkg::OFS_TX)
		begin
			if (wb_req.sel[0])
				d.txbuf[7:0] = wb_req.dat[7:0];
			if (wb_req.sel[1])
				d.txbuf[15:8] = wb_req.dat[15:8];
			d.tx_full = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			q       <= '0;
			q.st    <= spi_pkg::ST_IDLE;
			q.ste_n <= 1'b1;
			q.len   <= spi_pkg::RST_LEN;
			q.div   <= spi_pkg::RST_DIV;
		end
		else
			q <= d;
	end

	assign wb_rsp.ack          = q.ack;
	assign wb_rsp.dat          = q.rdat;
	assign serial_clock_line   = q.sclk;
	assign master_out_line     = q.mosi;
	assign slave_enable_line_n = q.ste_n;

	// Cycles spent in the current sequencer state, for checking only
	logic [spi_pkg::PER_W-1:0] dwell_q;
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || d.st != q.st)
			dwell_q <= '0;
		else
			dwell_q <= dwell_q + spi_pkg::PER_ONE;
	end

	AST_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst)
		period == ((q.div <= spi_pkg::DIV_SMALL_MAX) ? spi_pkg::MIN_PERIOD
			: {1'b0, q.div} + spi_pkg::PER_ONE) && act_len + idle_len == period)
		else $error("serial period does not follow the divider");
	AST_EVEN_RANGE: assert property (@(posedge core_clk) disable iff (sys_rst)
		!period[0] |-> period >= spi_pkg::MIN_PERIOD && period <= spi_pkg::MAX_PERIOD)
		else $error("even serial period out of range");
	AST_ODD_RANGE: assert property (@(posedge core_clk) disable iff (sys_rst)
		period[0] |-> period >= spi_pkg::ODD_MIN_PER && period <= spi_pkg::ODD_MAX_PER)
		else $error("odd serial period out of range");
	AST_ACT_HALF: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.st == spi_pkg::ST_ACT && d.st != spi_pkg::ST_ACT)
		|-> dwell_q == {1'b0, act_len} - spi_pkg::PER_ONE)
		else $error("active clock half has wrong length");
	AST_BIT_STABLE: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.st == spi_pkg::ST_GAP && d.st == spi_pkg::ST_ACT)
		|-> dwell_q == {1'b0, idle_len} - spi_pkg::PER_ONE ##1 $stable(master_out_line))
		else $error("data not presented a half period before sampling");
	AST_MODE: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(slave_enable_line_n) |-> $past(q.master) && $past(q.phase))
		else $error("word started without master and phase bits");
	AST_IDLE_LEVEL: assert property (@(posedge core_clk) disable iff (sys_rst)
		slave_enable_line_n |-> serial_clock_line == $past(q.pol))
		else $error("serial clock not at idle level while idle");
	AST_LEAD: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(slave_enable_line_n)
		|-> (serial_clock_line == q.pol && !slave_enable_line_n) [*2])
		else $error("enable lead before first edge too short");
	AST_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(slave_enable_line_n) |-> $past(q.st) == spi_pkg::ST_ACT
		&& $past(dwell_q) == {1'b0, act_len} - spi_pkg::PER_ONE)
		else $error("enable released at the wrong moment");
	AST_BACK2BACK: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.st == spi_pkg::ST_ACT && done && last_bit && q.tx_full && enabled)
		|=> !slave_enable_line_n && q.st == spi_pkg::ST_LEAD)
		else $error("enable dropped between back-to-back words");
	AST_POLARITY: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == spi_pkg::ST_ACT && $past(q.st) == spi_pkg::ST_ACT
		|-> serial_clock_line == !q.pol)
		else $error("active clock level does not follow polarity");
endmodule

//--- spi_pkg.sv
// Shared constants and types for the serial master with delayed clock phase.
// Assumes a 100 MHz core clock and a classic Wishbone register master.
package spi_pkg;

	localparam int DIV_W  = 7;
	localparam int PER_W  = 8;
	localparam int HALF_W = 7;
	localparam int WORD_W = 16;
	localparam int LEN_W  = 4;
	localparam int BITS_W = 5;
	localparam int ADR_W  = 8;

	// Clock and link rate figures
	localparam int CLK_PERIOD_NS = 10;
	localparam longint CLK_HZ    = 1_000_000_000 / CLK_PERIOD_NS;
	localparam longint TX_MAX_HZ = 25_000_000;
	localparam longint RX_MAX_HZ = 12_500_000;
	// Least serial period in core cycles, rounded up
	localparam logic [PER_W-1:0] TX_MIN_CYC =
		PER_W'((CLK_HZ + TX_MAX_HZ - 1) / TX_MAX_HZ);
	localparam logic [PER_W-1:0] RX_MIN_CYC =
		PER_W'((CLK_HZ + RX_MAX_HZ - 1) / RX_MAX_HZ);

	// Serial period figures
	localparam logic [PER_W-1:0]  MIN_PERIOD    = 8'h04;
	localparam logic [PER_W-1:0]  MAX_PERIOD    = 8'h80;
	localparam logic [PER_W-1:0]  ODD_MIN_PER   = 8'h05;
	localparam logic [PER_W-1:0]  ODD_MAX_PER   = 8'h7F;
	localparam logic [PER_W-1:0]  PER_ONE       = 8'h01;
	localparam logic [DIV_W-1:0]  DIV_SMALL_MAX = 7'h02;
	localparam logic [HALF_W-1:0] HALF_ONE      = 7'h01;
	localparam logic [BITS_W-1:0] BITS_ONE      = 5'h01;

	// Register byte offsets
	localparam logic [ADR_W-1:0] OFS_CFG  = 8'h00;
	localparam logic [ADR_W-1:0] OFS_CTL  = 8'h04;
	localparam logic [ADR_W-1:0] OFS_DIV  = 8'h08;
	localparam logic [ADR_W-1:0] OFS_STAT = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_TX   = 8'h10;
	localparam logic [ADR_W-1:0] OFS_RX   = 8'h14;

	// Field positions
	localparam int CFG_LEN_LSB    = 0;
	localparam int CFG_POL_BIT    = 6;
	localparam int CTL_MASTER_BIT = 2;
	localparam int CTL_PHASE_BIT  = 3;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_TXF_BIT   = 1;
	localparam int STAT_RXF_BIT   = 2;
	localparam int STAT_TXOK_BIT  = 3;
	localparam int STAT_RXOK_BIT  = 4;

	// Reset values
	localparam logic [LEN_W-1:0]  RST_LEN  = 4'hF;
	localparam logic [DIV_W-1:0]  RST_DIV  = 7'h00;
	localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
	localparam logic [31:0]       RD_ZERO  = 32'h0000_0000;

	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_ACT, ST_GAP} seq_t;

	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [3:0]       sel;
		logic [31:0]      dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		seq_t              st;
		logic [BITS_W-1:0] bits;
		logic [WORD_W-1:0] sh;
		logic [WORD_W-1:0] rx;
		logic [WORD_W-1:0] txbuf;
		logic [WORD_W-1:0] rxbuf;
		logic              tx_full;
		logic              rx_full;
		logic              pol;
		logic [LEN_W-1:0]  len;
		logic              master;
		logic              phase;
		logic [DIV_W-1:0]  div;
		logic              sclk;
		logic              mosi;
		logic              ste_n;
		logic              ack;
		logic [31:0]       rdat;
		logic              sync0;
		logic              sync1;
	} core_state_t;

	typedef struct packed {
		logic [HALF_W-1:0] cnt;
	} timer_state_t;

endpackage

//--- half_timer.sv
// Half-period timer: counts core cycles within one serial clock half.
// Assumes restart is driven from logic on the same clock.
`timescale 1ns/1ps
module half_timer
(
	input  logic                      core_clk,
	input  logic                      sys_rst,
	input  logic                      restart,
	input  logic [spi_pkg::HALF_W-1:0] half_len,
	output logic                      done
);
	spi_pkg::timer_state_t s_q;
	spi_pkg::timer_state_t s_d;

	assign done = (s_q.cnt == half_len - spi_pkg::HALF_ONE);

	always_comb
	begin
		s_d = s_q;
		if (restart)
			s_d.cnt = '0;
		else
			s_d.cnt = s_q.cnt + spi_pkg::HALF_ONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

//--- spi_slave_model.sv
// Serial slave model: captures what the master sends, returns a reply.
// Assumes the master owns the serial clock and the active-low enable.
`timescale 1ns/1ps
module spi_slave_model
(
	input  logic        serial_clock_line,
	input  logic        slave_enable_line_n,
	input  logic        master_out_line,
	input  logic        pol,
	input  logic [15:0] reply,
	output logic        master_in_line,
	output logic [15:0] got
);
	logic [15:0] sh;

	initial
	begin
		master_in_line = 1'b0;
		got = 16'h0000;
		sh = 16'h0000;
	end

	// First reply bit leads the clock by the whole lead half
	always @(negedge slave_enable_line_n)
	begin
		got = 16'h0000;
		sh = reply;
		master_in_line = sh[15];
	end

	// Sample on the idle-to-active edge, shift on the trailing one
	always @(serial_clock_line)
	begin
		if (!slave_enable_line_n && serial_clock_line != pol)
			got = {got[14:0], master_out_line};
		else if (!slave_enable_line_n)
		begin
			sh = {sh[14:0], 1'b0};
			master_in_line = sh[15];
		end
	end

	// A released line must not look like a held bit
	always @(posedge slave_enable_line_n)
		master_in_line = ~master_in_line;
endmodule

//--- spi_master_phase1_timing_tb_top.sv
// Bench for the delayed-phase serial master: clock, data and enable timing.
// Assumes spi_slave_model on the far side and the Wishbone register map.
`timescale 1ns/1ps
module spi_master_phase1_timing_tb_top;
	logic             core_clk;
	logic             sys_rst;
	spi_pkg::wb_req_t req;
	spi_pkg::wb_rsp_t rsp;
	logic             miso;
	logic             sclk;
	logic             mosi;
	logic             ste_n;
	logic             pol;
	logic [15:0]      reply;
	logic [15:0]      got;
	logic [31:0]      rdq;
	int               n_errors;
	int               checked;

	spi_master dut_u
	(
		.core_clk           (core_clk),
		.sys_rst            (sys_rst),
		.wb_req             (req),
		.wb_rsp             (rsp),
		.master_in_line     (miso),
		.serial_clock_line  (sclk),
		.master_out_line    (mosi),
		.slave_enable_line_n(ste_n)
	);

	spi_slave_model peer_u
	(
		.serial_clock_line  (sclk),
		.slave_enable_line_n(ste_n),
		.master_out_line    (mosi),
		.pol                (pol),
		.reply              (reply),
		.master_in_line     (miso),
		.got                (got)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Ack is sampled at rising edges; the request stands until one sees it
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		req <= '{1'b1, 1'b1, we, a, 4'hF, d};
		@(posedge core_clk);
		while (rsp.ack !== 1'b1)
			@(posedge core_clk);
		q = rsp.dat;
		req <= '0;
		@(posedge core_clk);
	endtask

	task automatic word(input logic [6:0] dv, input logic pl,
		input logic [3:0] ln, input logic [15:0] tx, input logic two);
		int p, act, nb, t, run, ed, k;
		logic a, pa;
		logic [31:0] q, x;
		p = (dv <= 7'h02) ? 4 : int'(dv) + 1;
		act = p / 2;
		nb = int'(ln) + 1;
		k = two ? 2 : 1;
		pol = pl;
		reply = ~tx;
		wb(1'b1, spi_pkg::OFS_CFG, {25'h0, pl, 2'h0, ln}, q);
		wb(1'b1, spi_pkg::OFS_DIV, {25'h0, dv}, q);
		wb(1'b1, spi_pkg::OFS_TX, {16'h0, tx}, q);
		wb(1'b0, spi_pkg::OFS_CFG, 32'h0000_0000, q);
		chk("config", q, {25'h0, pl, 2'h0, ln});
		wb(1'b0, spi_pkg::OFS_DIV, 32'h0000_0000, q);
		chk("divider", q, {25'h0, dv});
		wb(1'b0, spi_pkg::OFS_STAT, 32'h0000_0000, q);
		chk("status", q, {27'h0, 1'(p >= 8), 4'hA});
		fork
		begin
			wb(1'b1, spi_pkg::OFS_CTL, 32'h0000_000C, x);
			if (two)
				wb(1'b1, spi_pkg::OFS_TX, {16'h0, tx}, x);
		end
		join_none
		t = 0;
		while (ste_n !== 1'b0 && t++ < 100)
			@(negedge core_clk);
		chk("start", ste_n, 1'b0);
		chk("first bit", mosi, tx[15]);
		t = 0;
		run = 0;
		ed = 0;
		pa = 1'b0;
		while (ste_n === 1'b0 && t < 3000)
		begin
			a = sclk ^ pl;
			if (a !== pa && a)
			begin
				chk("lead half", 32'(run), 32'(p - act));
				chk("bit", mosi, tx[15 - ed % nb]);
				ed++;
			end
			else if (a !== pa)
				chk("active half", 32'(run), 32'(act));
			run = (a !== pa) ? 1 : run + 1;
			pa = a;
			t++;
			@(negedge core_clk);
		end
		chk("enable span", 32'(t), 32'(k * nb * p));
		chk("edges", 32'(ed), 32'(k * nb));
		chk("idle level", sclk, pl);
		if (!two)
			chk("slave got", got & 16'((1 << nb) - 1), tx >> (16 - nb));
		wb(1'b1, spi_pkg::OFS_CTL, 32'h0000_0000, q);
		wb(1'b0, spi_pkg::OFS_RX, 32'h0000_0000, q);
		// Receive is judged only at rates the link allows for it
		if (!two && p >= 8)
			chk("reply", q, 32'(reply >> (16 - nb)));
	endtask

	task automatic refuse;
		logic [31:0] q;
		int i;
		wb(1'b1, spi_pkg::OFS_TX, 32'h0000_1234, q);
		for (i = 1; i < 3; i++)
		begin
			wb(1'b1, spi_pkg::OFS_CTL, 32'(i << 2), q);
			repeat (20) @(negedge core_clk);
			chk("held idle", ste_n, 1'b1);
		end
		wb(1'b1, spi_pkg::OFS_CTL, 32'h0000_0000, q);
	endtask

	task automatic summarize;
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		summarize();
	end

	initial
	begin
		sys_rst = 1'b1;
		req = '0;
		pol = 1'b0;
		reply = 16'h0000;
		n_errors = 0;
		checked = 0;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk("rest clock", sclk, 1'b0);
		chk("rest enable", ste_n, 1'b1);
		wb(1'b0, 8'h20, 32'h0000_0000, rdq);
		chk("unmapped", rdq, 32'h0000_0000);
		word(7'h00, 1'b0, 4'h1, 16'hA5C3, 1'b0);
		word(7'h02, 1'b1, 4'h7, 16'h3C5A, 1'b0);
		word(7'h04, 1'b1, 4'h3, 16'h9E00, 1'b0);
		word(7'h07, 1'b0, 4'hF, 16'hC3A5, 1'b0);
		word(7'h05, 1'b0, 4'h3, 16'hB000, 1'b1);
		word(7'h7E, 1'b1, 4'h0, 16'h8000, 1'b0);
		word(7'h7F, 1'b0, 4'h0, 16'h7FFF, 1'b0);
		refuse();
		summarize();
	end
endmodule
